// file: design/ckd_consts.svh
// Constants for the clock source and distribution block
`ifndef CKD_CONSTS_SVH
`define CKD_CONSTS_SVH

// Register byte offsets
`define CKD_OFF_MAIN      8'h00
`define CKD_OFF_PERIPH    8'h04
`define CKD_OFF_FLL       8'h08
`define CKD_OFF_STATUS    8'h0C

// Main control fields
`define CKD_MAIN_SRC_LSB  0
`define CKD_MAIN_DIV_LSB  4
`define CKD_SUB_DIV_LSB   8
`define CKD_AUX_SRC_BIT   12

// Peripheral select fields
`define CKD_TMR_SEL_LSB   0
`define CKD_SER_SEL_LSB   2
`define CKD_WDG_SEL_LSB   4
`define CKD_CNV_SEL_LSB   6
`define CKD_RTC_SEL_LSB   8
`define CKD_RTC_CHO_BIT   12

// Frequency loop fields
`define CKD_FLL_MUL_LSB   0
`define CKD_FLL_EN_BIT    16
`define CKD_FLL_REF_BIT   17

// Status fields
`define CKD_ST_FAULT_BIT  0
`define CKD_ST_LOCK_BIT   1
`define CKD_ST_SEEN_BIT   2
`define CKD_ST_TRIM_LSB   16

// Reset values
`define CKD_RST_MAIN      32'h0000_0000
`define CKD_RST_PERIPH    32'h0000_0000
`define CKD_RST_FLL       32'h0000_01E8
`define CKD_RST_TRIM      10'h200

// Pin input indices
`define CKD_IN_CTL        0
`define CKD_IN_RC         1
`define CKD_IN_XTAL       2
`define CKD_IN_LPO        3
`define CKD_IN_MOD        4
`define CKD_IN_TMR        5
`define CKD_IN_SER        6
`define CKD_NUM_IN        7

// Timing and frequency figures
`define CKD_CLK_PERIOD_NS  8
`define CKD_XTAL_TIMEOUT_NS 200000
`define CKD_MAIN_MAX_KHZ   16000
`define CKD_AUX_MAX_KHZ    40
`define CKD_MOD_KHZ        4000
`define CKD_LPO_KHZ        10

`endif

// file: design/ckd_pkg.sv
// Types shared by the clock source and distribution block
package ckd_pkg;
  typedef logic [1:0] ckd_code_t;
  typedef logic [2:0] ckd_sel_t;
  typedef logic [2:0] ckd_exp_t;
  typedef logic [9:0] ckd_trim_t;
  typedef logic [7:0] ckd_edges_t;
endpackage

// file: design/ckd_clk_chan.sv
// Glitch-free selectable clock channel with power-of-two divider
`timescale 1ns/1ps
module ckd_clk_chan
  import ckd_pkg::*;
(
  // Clock, reset and enable
  input  wire logic            clock,
  input  wire logic            rst_b,
  input  wire logic            ce,
  // Source edges and settings
  input  wire ckd_pkg::ckd_edges_t srcEdge,
  input  wire ckd_pkg::ckd_sel_t   sel,
  input  wire ckd_pkg::ckd_exp_t   divExp,
  // Output clock level and toggle strobe
  output logic                 clkOut,
  output logic                 clkEdge
);
  import ckd_pkg::*;

  ckd_sel_t   curSel;
  ckd_exp_t   curExp;
  logic [6:0] halfCnt;
  logic [6:0] halfTop;
  logic       srcHit;

  // Source edges per half period, minus one
  assign halfTop = 7'((8'h01 << curExp) - 8'h01);
  assign srcHit  = srcEdge[curSel];

  // Settings move only while the output is low: no short pulses
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      curSel <= 3'h0;
      curExp <= 3'h0;
    end
    else if (ce && !clkOut)
    begin
      curSel <= sel;
      curExp <= divExp;
    end
  end

  // Half-period counter and output toggle
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      halfCnt <= 7'h00;
      clkOut  <= 1'b0;
      clkEdge <= 1'b0;
    end
    else if (ce)
    begin
      clkEdge <= 1'b0;
      if (!clkOut && (sel != curSel || divExp != curExp))
        halfCnt <= 7'h00; // Restart low half on the new setting
      else if (srcHit)
      begin
        if (halfCnt == halfTop)
        begin
          halfCnt <= 7'h00;
          clkOut  <= !clkOut;
          clkEdge <= 1'b1;
        end
        else
          halfCnt <= halfCnt + 7'h01;
      end
    end
  end
endmodule

// file: design/ckd_clock_dist.sv
// Clock source selection, division and distribution with register bus
// Behaviour
// [R1] Main clock picks crystal, RC, controlled or low-power osc, div 1-128.
// [R2] Subsystem clock is main clock divided by 1, 2, 4 or 8.
// [R3] Auxiliary clock comes from crystal or RC reference, up to 40 kHz.
// [R4] Core, memories, checksum and ports run on main clock, no select.
// [R5] Main and subsystem up to 16 MHz; modulation 4 MHz; low-power 10 kHz.
// [R6] Timer select: 00 pin, 01 auxiliary, 10 subsystem clock.
// [R7] Serial select: 00 pin, 01 auxiliary, 10 or 11 subsystem clock.
// [R8] Watchdog select: 00 subsystem, 01 auxiliary, 10 low-power osc.
// [R9] Converter select: 00 modulation, 01 auxiliary, 10 or 11 subsystem.
// [R10] Counter code 01 takes subsystem or auxiliary per a bit; 11 low-power.
// [R11] Controlled oscillator locks by a loop to internal or crystal ref.
// [R12] Crystal failure is caught and the RC reference stands in for it.
// [R13] Source or divider changes never make truncated or glitched pulses.
`timescale 1ns/1ps
`include "ckd_consts.svh"
module ckd_clock_dist
  import ckd_pkg::*;
#(
  parameter int unsigned XTAL_TIMEOUT_CYC =
    `CKD_XTAL_TIMEOUT_NS / `CKD_CLK_PERIOD_NS
)
(
  // Clock, reset and enable
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Oscillator and pin clocks (asynchronous)
  input  wire logic        oscClkIn,
  input  wire logic        rcClkIn,
  input  wire logic        xtalClkIn,
  input  wire logic        lpoClkIn,
  input  wire logic        modClkIn,
  input  wire logic        timerExtClkPin,
  input  wire logic        serialExtClkPin,
  // Distributed clocks
  output logic             mainClock,
  output logic             subsystemClock,
  output logic             auxClock,
  output logic             timerClock,
  output logic             serialClock,
  output logic             watchdogClock,
  output logic             converterClock,
  output logic             rtcClock,
  // Oscillator control and state
  output ckd_pkg::ckd_trim_t oscTrim,
  output logic             fllLocked,
  output logic             xtalFault
);
  import ckd_pkg::*;

  // Register address match, used by both read and write paths
  function automatic logic isReg(input logic [7:0] a, input logic [7:0] off);
    isReg = (a == off);
  endfunction

  // Registers
  logic [31:0] mainCtrl;
  logic [31:0] periphCtrl;
  logic [31:0] fllCtrl;
  logic        faultSeen;
  // Bus data phase
  logic        wrPend;
  logic [7:0]  wrAddr;
  logic        addrTaken;
  // Input synchronisers
  logic [`CKD_NUM_IN-1:0] syncA;
  logic [`CKD_NUM_IN-1:0] syncB;
  logic [`CKD_NUM_IN-1:0] syncC;
  logic [`CKD_NUM_IN-1:0] inEdge;
  // Fail-safe
  logic [15:0] xtalIdle;
  logic        xtalEffEdge;
  logic        xtalEffLevel;
  // Frequency loop
  logic [11:0] oscCount;
  logic        refRise;
  logic        refLevelQ;
  // Channel strobes
  logic        mainEdge;
  logic        subEdge;
  logic        auxEdge;
  ckd_edges_t  mainSrc;
  ckd_edges_t  subSrc;
  ckd_edges_t  auxSrc;
  ckd_edges_t  tmrSrc;
  ckd_edges_t  serSrc;
  ckd_edges_t  wdgSrc;
  ckd_edges_t  cnvSrc;
  ckd_edges_t  rtcSrc;
  logic [31:0] next_hrdata;

  // Bus always OKAY; ready follows the enable so no phase is lost
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign addrTaken = hsel && htrans[1] && hready;

  // Address phase capture for writes
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end
    else if (ce)
    begin
      wrPend <= addrTaken && hwrite && hsize == 3'h2;
      wrAddr <= haddr[7:0];
    end
  end

  // Read data registered at the address phase
  always_comb
  begin
    next_hrdata = 32'h0000_0000;
    if (isReg(haddr[7:0], `CKD_OFF_MAIN))
      next_hrdata = mainCtrl;
    else if (isReg(haddr[7:0], `CKD_OFF_PERIPH))
      next_hrdata = periphCtrl;
    else if (isReg(haddr[7:0], `CKD_OFF_FLL))
      next_hrdata = fllCtrl;
    else if (isReg(haddr[7:0], `CKD_OFF_STATUS))
    begin
      next_hrdata[`CKD_ST_FAULT_BIT] = xtalFault;
      next_hrdata[`CKD_ST_LOCK_BIT]  = fllLocked;
      next_hrdata[`CKD_ST_SEEN_BIT]  = faultSeen;
      next_hrdata[`CKD_ST_TRIM_LSB +: 10] = oscTrim;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      hrdata <= 32'h0000_0000;
    else if (ce && addrTaken && !hwrite)
      hrdata <= next_hrdata;
  end

  // Control registers, only implemented bits stored
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      mainCtrl   <= `CKD_RST_MAIN;
      periphCtrl <= `CKD_RST_PERIPH;
      fllCtrl    <= `CKD_RST_FLL;
    end
    else if (ce && wrPend)
    begin
      if (isReg(wrAddr, `CKD_OFF_MAIN))
        mainCtrl <= hwdata & 32'h0000_1373;
      if (isReg(wrAddr, `CKD_OFF_PERIPH))
        periphCtrl <= hwdata & 32'h0000_13FF;
      if (isReg(wrAddr, `CKD_OFF_FLL))
        fllCtrl <= hwdata & 32'h0003_03FF;
    end
  end

  // Two-flop synchronisers, third stage for edge detect
  genvar gi;
  generate
    for (gi = 0; gi < `CKD_NUM_IN; gi = gi + 1)
    begin : gSync
      always_ff @(posedge clock)
      begin
        if (!rst_b)
        begin
          syncA[gi] <= 1'b0;
          syncB[gi] <= 1'b0;
          syncC[gi] <= 1'b0;
        end
        else if (ce)
        begin
          syncA[gi] <= (gi == `CKD_IN_CTL)  ? oscClkIn :
                       (gi == `CKD_IN_RC)   ? rcClkIn :
                       (gi == `CKD_IN_XTAL) ? xtalClkIn :
                       (gi == `CKD_IN_LPO)  ? lpoClkIn :
                       (gi == `CKD_IN_MOD)  ? modClkIn :
                       (gi == `CKD_IN_TMR)  ? timerExtClkPin :
                                              serialExtClkPin;
          syncB[gi] <= syncA[gi];
          syncC[gi] <= syncB[gi];
        end
      end
      // Both edges; 125 MHz sampling covers sources up to 16 MHz
      assign inEdge[gi] = syncB[gi] ^ syncC[gi]; // see [R5]
    end
  endgenerate

  // Crystal watchdog: no edge for the timeout flags a fault
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      xtalIdle  <= 16'h0000;
      xtalFault <= 1'b0;
    end
    else if (ce)
    begin
      if (inEdge[`CKD_IN_XTAL])
      begin
        xtalIdle  <= 16'h0000;
        xtalFault <= 1'b0;
      end
      else if (xtalIdle == 16'(XTAL_TIMEOUT_CYC))
        xtalFault <= 1'b1; // see [R12]
      else
        xtalIdle <= xtalIdle + 16'h0001;
    end
  end

  // Sticky fault record, write one to clear, new fault wins
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      faultSeen <= 1'b0;
    else if (ce)
    begin
      if (xtalFault)
        faultSeen <= 1'b1; // see [R12]
      else if (wrPend && isReg(wrAddr, `CKD_OFF_STATUS) &&
               hwdata[`CKD_ST_SEEN_BIT])
        faultSeen <= 1'b0;
    end
  end

  // RC reference stands in for a failed crystal
  assign xtalEffEdge  = xtalFault ? inEdge[`CKD_IN_RC] : inEdge[`CKD_IN_XTAL];
  assign xtalEffLevel = xtalFault ? syncB[`CKD_IN_RC] : syncB[`CKD_IN_XTAL];

  // Frequency loop: count controlled-osc rises per reference rise
  assign refRise = (fllCtrl[`CKD_FLL_REF_BIT] ? xtalEffLevel
                    : syncB[`CKD_IN_RC]) && !refLevelQ;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      refLevelQ <= 1'b0;
      oscCount  <= 12'h000;
      oscTrim   <= `CKD_RST_TRIM;
      fllLocked <= 1'b0;
    end
    else if (ce)
    begin
      refLevelQ <= fllCtrl[`CKD_FLL_REF_BIT] ? xtalEffLevel
                   : syncB[`CKD_IN_RC];
      if (!fllCtrl[`CKD_FLL_EN_BIT])
      begin
        oscCount  <= 12'h000;
        fllLocked <= 1'b0;
      end
      else if (refRise)
      begin
        oscCount  <= 12'h000;
        fllLocked <= oscCount == {2'b00, fllCtrl[9:0]};
        if (oscCount < {2'b00, fllCtrl[9:0]} && oscTrim != 10'h3FF)
          oscTrim <= oscTrim + 10'h001; // see [R11]
        else if (oscCount > {2'b00, fllCtrl[9:0]} && oscTrim != 10'h000)
          oscTrim <= oscTrim - 10'h001; // see [R11]
      end
      else if (inEdge[`CKD_IN_CTL] && syncB[`CKD_IN_CTL] &&
               oscCount != 12'hFFF)
        oscCount <= oscCount + 12'h001;
    end
  end

  // Source maps; modulation osc never reaches the main clock
  assign mainSrc = {4'h0, inEdge[`CKD_IN_LPO], xtalEffEdge,
                    inEdge[`CKD_IN_RC], inEdge[`CKD_IN_CTL]}; // see [R1]
  assign subSrc  = {7'h00, mainEdge}; // see [R2]
  assign auxSrc  = {6'h00, inEdge[`CKD_IN_RC], xtalEffEdge}; // see [R3]
  assign tmrSrc  = {5'h00, subEdge, auxEdge,
                    inEdge[`CKD_IN_TMR]}; // see [R6]
  assign serSrc  = {4'h0, subEdge, subEdge, auxEdge,
                    inEdge[`CKD_IN_SER]}; // see [R7]
  assign wdgSrc  = {5'h00, inEdge[`CKD_IN_LPO], auxEdge,
                    subEdge}; // see [R8]
  assign cnvSrc  = {4'h0, subEdge, subEdge, auxEdge,
                    inEdge[`CKD_IN_MOD]}; // see [R9]
  // Upper half of the index picks auxiliary for code 01
  assign rtcSrc  = {inEdge[`CKD_IN_LPO], xtalEffEdge, auxEdge, 1'b0,
                    inEdge[`CKD_IN_LPO], xtalEffEdge, subEdge,
                    1'b0}; // see [R10]

  // Main clock, also the fixed clock of core, memories and ports
  ckd_clk_chan uMain (
    .clock   (clock),
    .rst_b   (rst_b),
    .ce      (ce),
    .srcEdge (mainSrc),
    .sel     ({1'b0, mainCtrl[`CKD_MAIN_SRC_LSB +: 2]}),
    .divExp  (mainCtrl[`CKD_MAIN_DIV_LSB +: 3]), // see [R1] [R13]
    .clkOut  (mainClock), // see [R4]
    .clkEdge (mainEdge)
  );

  // Subsystem clock from the main clock
  ckd_clk_chan uSub (
    .clock   (clock),
    .rst_b   (rst_b),
    .ce      (ce),
    .srcEdge (subSrc),
    .sel     (3'h0),
    .divExp  ({1'b0, mainCtrl[`CKD_SUB_DIV_LSB +: 2]}), // see [R2]
    .clkOut  (subsystemClock),
    .clkEdge (subEdge)
  );

  // Auxiliary clock
  ckd_clk_chan uAux (
    .clock   (clock),
    .rst_b   (rst_b),
    .ce      (ce),
    .srcEdge (auxSrc),
    .sel     ({2'b00, mainCtrl[`CKD_AUX_SRC_BIT]}), // see [R3]
    .divExp  (3'h0),
    .clkOut  (auxClock),
    .clkEdge (auxEdge)
  );

  // Timer clock
  ckd_clk_chan uTmr (
    .clock   (clock),
    .rst_b   (rst_b),
    .ce      (ce),
    .srcEdge (tmrSrc),
    .sel     ({1'b0, periphCtrl[`CKD_TMR_SEL_LSB +: 2]}), // see [R6]
    .divExp  (3'h0),
    .clkOut  (timerClock),
    .clkEdge ()
  );

  // Serial interface clock
  ckd_clk_chan uSer (
    .clock   (clock),
    .rst_b   (rst_b),
    .ce      (ce),
    .srcEdge (serSrc),
    .sel     ({1'b0, periphCtrl[`CKD_SER_SEL_LSB +: 2]}), // see [R7]
    .divExp  (3'h0),
    .clkOut  (serialClock),
    .clkEdge ()
  );

  // Watchdog clock; code 11 gives no clock
  ckd_clk_chan uWdg (
    .clock   (clock),
    .rst_b   (rst_b),
    .ce      (ce),
    .srcEdge (wdgSrc),
    .sel     ({1'b0, periphCtrl[`CKD_WDG_SEL_LSB +: 2]}), // see [R8]
    .divExp  (3'h0),
    .clkOut  (watchdogClock),
    .clkEdge ()
  );

  // Converter clock
  ckd_clk_chan uCnv (
    .clock   (clock),
    .rst_b   (rst_b),
    .ce      (ce),
    .srcEdge (cnvSrc),
    .sel     ({1'b0, periphCtrl[`CKD_CNV_SEL_LSB +: 2]}), // see [R9]
    .divExp  (3'h0),
    .clkOut  (converterClock),
    .clkEdge ()
  );

  // Real-time counter clock; choice bit joins the select
  ckd_clk_chan uRtc (
    .clock   (clock),
    .rst_b   (rst_b),
    .ce      (ce),
    .srcEdge (rtcSrc),
    .sel     ({periphCtrl[`CKD_RTC_CHO_BIT],
               periphCtrl[`CKD_RTC_SEL_LSB +: 2]}), // see [R10]
    .divExp  (3'h0),
    .clkOut  (rtcClock),
    .clkEdge ()
  );
endmodule

// file: sim/ckd_clock_dist_assertions.sv
// Port checker for the clock source and distribution block
`timescale 1ns/1ps
module ckd_dist_chk
  import ckd_pkg::*;
#(
  parameter int unsigned XTAL_TIMEOUT_CYC = 25000
)
(
  // Clock, reset and watched inputs
  input wire logic               clock,
  input wire logic               rst_b,
  input wire logic               ce,
  input wire logic               xtalClkIn,
  // Watched outputs
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic               mainClock,
  input wire logic               subsystemClock,
  input wire logic               auxClock,
  input wire ckd_pkg::ckd_trim_t oscTrim,
  input wire logic               xtalFault
);
  int unsigned quiet;
  logic [1:0]  settle;

  // Cycles since reset, and since the crystal pin last moved
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      quiet  <= 0;
      settle <= 2'h0;
    end
    else
    begin
      if (settle != 2'h3)
        settle <= settle + 2'h1;
      if (ce)
        quiet <= $changed(xtalClkIn) ? 0 : quiet + 1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Bus handshake and response
  a_bus_okay:
    assert property (hresp == 1'b0)
    else $error("bus response not OKAY");
  a_ready_ce:
    assert property (hreadyout == ce)
    else $error("ready differs from enable");
  // Subsystem clock moves one cycle after the main clock
  a_sub_after_main:
    assert property (settle == 2'h3 && ce && $past(ce) &&
      $changed(subsystemClock) |-> $past(mainClock) != $past(mainClock, 2))
    else $error("subsystem toggled without a main toggle");
  // Stalled block keeps the main, subsystem and auxiliary levels and the trim; reset leaves them idle
  a_ce_freeze:
    assert property (!ce |=> $stable(mainClock) && $stable(subsystemClock)
      && $stable(auxClock) && $stable(oscTrim))
    else $error("state moved while stalled");
  a_reset_idle:
    assert property (disable iff (1'b0) !rst_b |=> !mainClock &&
      !subsystemClock && !auxClock && !xtalFault && oscTrim == 10'h200)
    else $error("outputs not idle after reset");
  // Crystal fault timing and trim step size
  a_fault_late:
    assert property ($rose(xtalFault) |-> quiet >= XTAL_TIMEOUT_CYC)
    else $error("fault flagged before the timeout");
  a_fault_prompt:
    assert property (quiet >= XTAL_TIMEOUT_CYC + 8 |-> xtalFault)
    else $error("fault not flagged after the timeout");
  a_fault_clear:
    assert property (xtalFault && $changed(xtalClkIn) |-> ##[1:5] !xtalFault)
    else $error("fault not cleared by a crystal edge");
  a_trim_step:
    assert property (settle == 2'h3 && $changed(oscTrim) |->
      oscTrim == $past(oscTrim) + 10'h001 ||
      oscTrim == $past(oscTrim) - 10'h001)
    else $error("trim moved by more than one step");

  // Main scenarios reached
  c_sub_toggle: cover property ($changed(subsystemClock));
  c_fault: cover property ($rose(xtalFault));
  c_trim: cover property ($changed(oscTrim));
endmodule

bind ckd_clock_dist ckd_dist_chk #(.XTAL_TIMEOUT_CYC(XTAL_TIMEOUT_CYC)) chk (
  .clock(clock), .rst_b(rst_b), .ce(ce), .xtalClkIn(xtalClkIn),
  .hreadyout(hreadyout), .hresp(hresp), .mainClock(mainClock),
  .subsystemClock(subsystemClock), .auxClock(auxClock),
  .oscTrim(oscTrim), .xtalFault(xtalFault));

// file: sim/tb.sv
// Self-checking testbench for the clock source and distribution block
`timescale 1ns/1ps
`include "ckd_consts.svh"
module tb;
  import ckd_pkg::*;
  localparam int TO = 50;
  // Half periods of timer, serial, watchdog, converter, counter per row
  localparam int EXP [5][5] = '{'{4, 8, 128, 2, 0}, '{32, 32, 32, 32, 128},
    '{128, 128, 64, 128, 32}, '{0, 128, 0, 128, 64}, '{32, 32, 32, 32, 32}};
  logic        clock     = 1'b0;
  logic        rst_b     = 1'b0;
  logic        ce        = 1'b1;
  logic        hwrite    = 1'b0;
  logic        xtOn      = 1'b1;
  logic [1:0]  htrans    = 2'h0;
  logic [2:0]  hsize     = 3'h2;
  logic [31:0] haddr     = 32'h0;
  logic [31:0] hwdata    = 32'h0;
  logic [7:0]  cyc       = 8'h00;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        fllLocked;
  logic        xtalFault;
  logic [7:0]  outs;
  ckd_trim_t   oscTrim;
  int          bad_count = 0;
  int          compares  = 0;

  // Clock; source bit b has a half period of 2^b cycles
  always #4 clock = ~clock;
  always @(posedge clock)
    cyc <= cyc + 8'h01;

  ckd_clock_dist #(.XTAL_TIMEOUT_CYC(TO)) dut (
    .clock(clock), .rst_b(rst_b), .ce(ce), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .oscClkIn(cyc[0]), .modClkIn(cyc[1]), .timerExtClkPin(cyc[2]),
    .serialExtClkPin(cyc[3]), .rcClkIn(cyc[4]),
    .xtalClkIn(cyc[5] & xtOn), .lpoClkIn(cyc[6]), .mainClock(outs[0]),
    .subsystemClock(outs[1]), .auxClock(outs[2]), .timerClock(outs[3]),
    .serialClock(outs[4]), .watchdogClock(outs[5]),
    .converterClock(outs[6]), .rtcClock(outs[7]), .oscTrim(oscTrim),
    .fllLocked(fllLocked), .xtalFault(xtalFault));

  // Compare and count
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One single bus transfer, address then data phase
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clock);
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  // Read and compare the masked word
  task automatic rdc(logic [7:0] a, logic [31:0] m, logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check($sformatf("register %h", a), q & m, e);
  endtask

  // Last half period and shortest full half over cnt toggles
  task automatic half(int idx, int cnt, output int h, output int m);
    logic v;
    h = 0;
    m = 999;
    for (int k = 0; k < cnt && h < 700; k++)
    begin
      v = outs[idx];
      h = 0;
      while (outs[idx] === v && h < 700)
      begin
        @(posedge clock);
        h++;
      end
      if (k > 0 && h < m)
        m = h;
    end
    if (h >= 700)
      h = 0;
  endtask

  task automatic hc(int idx, int e);
    int h;
    int m;
    half(idx, 4, h, m);
    check($sformatf("half of output %0d", idx), 32'(h), 32'(e));
  endtask

  // Reset values, unmapped and read-only writes
  task automatic t_regs;
    rdc(`CKD_OFF_MAIN, 32'hFFFF_FFFF, `CKD_RST_MAIN);
    rdc(`CKD_OFF_PERIPH, 32'hFFFF_FFFF, `CKD_RST_PERIPH);
    rdc(`CKD_OFF_FLL, 32'hFFFF_FFFF, `CKD_RST_FLL);
    rdc(`CKD_OFF_STATUS, 32'h03FF_0005, {6'h00, `CKD_RST_TRIM, 16'h0000});
    rdc(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h10, 32'h0000_0007);
    wr(`CKD_OFF_STATUS, 32'h03FF_0003);
    rdc(`CKD_OFF_MAIN, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(`CKD_OFF_STATUS, 32'h03FF_0001, {6'h00, `CKD_RST_TRIM, 16'h0000});
    $display("test registers done");
  endtask

  // Main sources and dividers, subsystem divider, auxiliary source
  task automatic t_main;
    for (int d = 0; d < 8; d++)
    begin
      wr(`CKD_OFF_MAIN, 32'(d) << 4);
      hc(0, 1 << d);
    end
    for (int s = 1; s < 4; s++)
    begin
      wr(`CKD_OFF_MAIN, 32'(s));
      hc(0, 8 << s);
    end
    for (int s = 0; s < 4; s++)
    begin
      wr(`CKD_OFF_MAIN, 32'(s) << 8);
      hc(1, 1 << s);
    end
    hc(2, 32);
    wr(`CKD_OFF_MAIN, 32'h0000_1000);
    hc(2, 16);
    $display("test main clocks done");
  endtask

  // Every code of every peripheral select
  task automatic t_periph;
    logic [31:0] c;
    wr(`CKD_OFF_MAIN, 32'h0000_0340);
    for (int r = 0; r < 5; r++)
    begin
      c = (r < 4) ? 32'(r) : 32'h1;
      wr(`CKD_OFF_PERIPH, c * 32'h155 | ((r == 4) ? 32'h1000 : 32'h0));
      for (int j = 0; j < 5; j++)
        hc(j + 3, EXP[r][j]);
    end
    $display("test peripheral selects done");
  endtask

  // Crystal stops, RC stands in, crystal returns
  task automatic t_fault;
    xtOn <= 1'b0;
    repeat (TO + 20) @(posedge clock);
    check("fault", 32'(xtalFault), 32'h1);
    rdc(`CKD_OFF_STATUS, 32'h0000_0005, 32'h0000_0005);
    hc(2, 16);
    xtOn <= 1'b1;
    repeat (80) @(posedge clock);
    check("fault gone", 32'(xtalFault), 32'h0);
    wr(`CKD_OFF_STATUS, 32'h0000_0004);
    rdc(`CKD_OFF_STATUS, 32'h0000_0005, 32'h0000_0000);
    $display("test crystal fault done");
  endtask

  // Loop locks to either reference, then trims up
  task automatic t_loop;
    ckd_trim_t t;
    wr(`CKD_OFF_FLL, 32'h0001_0010);
    repeat (200) @(posedge clock);
    t = oscTrim;
    check("lock on RC", 32'(fllLocked), 32'h1);
    repeat (100) @(posedge clock);
    check("trim held", 32'(oscTrim), 32'(t));
    wr(`CKD_OFF_FLL, 32'h0003_0020);
    repeat (300) @(posedge clock);
    check("lock on crystal", 32'(fllLocked), 32'h1);
    wr(`CKD_OFF_FLL, 32'h0003_03FF);
    repeat (300) @(posedge clock);
    check("trim raised", 32'(oscTrim > t), 32'h1);
    $display("test frequency loop done");
  endtask

  // Source switch without short halves, then a stall
  task automatic t_glitch;
    int h;
    int m;
    logic [7:0] o;
    wr(`CKD_OFF_MAIN, 32'h0000_0003);
    half(0, 2, h, m);
    wr(`CKD_OFF_MAIN, 32'h0000_0001);
    half(0, 6, h, m);
    check("shortest main half", 32'(m), 32'h10);
    ce <= 1'b0;
    @(posedge clock);
    o = outs;
    repeat (20) @(posedge clock);
    check("stalled ready", 32'(hreadyout), 32'h0);
    check("stalled clocks", 32'(outs), 32'(o));
    ce <= 1'b1;
    $display("test switch and stall done");
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Cuts a hang short
  initial
  begin
    repeat (90000) @(posedge clock);
    bad_count++;
    end_of_test();
  end

  // Reset, then the scenarios in turn
  initial
  begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_main();
    t_periph();
    t_fault();
    t_loop();
    t_glitch();
    end_of_test();
  end
endmodule
